// ---- hw/ready_pkg.sv ----
// Constants and types for the bus READY wait control block
package ready_pkg;
    localparam int ACCESS_MIN = 1;
    localparam int ACCESS_MAX = 32;
    localparam int PHASE_W = 6;
    localparam int DATA_W = 16;
    localparam int SYNC_DEPTH = 2;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 6'h01;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_READY_WAIT = 2'b11,
        ST_DONE = 2'b10
    } cycle_state_t;
endpackage

// ---- hw/ready_sync_if.sv ----
// Interface carrying the synchronised READY levels between modules
`timescale 1ns/1ns
interface ready_sync_if;
    logic ready_direct;
    logic ready_synced;
    modport src (output ready_direct, output ready_synced);
    modport dst (input ready_direct, input ready_synced);
endinterface

// ---- hw/ready_sync.sv ----
// Two-flop synchroniser for the READY pin
`timescale 1ns/1ns
module ready_sync
    import ready_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ready_pin, // READY pin level
    ready_sync_if.src sync // Synchronised levels
);
    logic [SYNC_DEPTH-1:0] stage;
    logic [SYNC_DEPTH-1:0] next_stage;
    logic extra;
    logic next_extra;

    always_comb
    begin
        next_stage = {stage[SYNC_DEPTH-2:0], ready_pin};
        next_extra = stage[SYNC_DEPTH-1];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage <= '0;
            extra <= 1'b0;
        end
        else
        begin
            stage <= next_stage;
            extra <= next_extra;
        end
    end

    // Direct path is the stage-two output: pins always pass two flops
    assign sync.ready_direct = stage[SYNC_DEPTH-1];
    // Asynchronous path gets one more flop, hence the later instant
    assign sync.ready_synced = extra;
endmodule

// ---- hw/bus_ready_wait_control.sv ----
// Bus cycle length control with READY-driven waitstates
`timescale 1ns/1ns
module bus_ready_wait_control
    import ready_pkg::*;
#(
    parameter int ACCESS_LEN_MAX = ACCESS_MAX
)
(
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic rst_n, // Async reset, active low
    output logic reference_clock_output, // Reference clock view, the system clock itself
    input wire logic ready_pin, // READY input pin
    input wire logic ready_active_high, // 1: READY active high
    input wire logic ready_async, // 1: asynchronous READY mode
    input wire logic ready_enable, // 1: cycle is READY-controlled
    input wire logic [ready_pkg::PHASE_W-1:0] access_phase, // Access waits
    input wire logic cycle_start, // Pulse: start a bus cycle
    input wire logic cycle_is_read, // Cycle is a read
    input wire logic [ready_pkg::DATA_W-1:0] data_in, // Bus read data
    output logic cmd_strobe_n, // Read/write command strobe, low
    output logic in_ready_wait, // In a ready_wait_phase state
    output logic cycle_end, // Pulse: cycle terminated
    output logic [ready_pkg::DATA_W-1:0] read_data, // Captured data
    output logic busy // Cycle in progress
);
    // Elaboration checks: values the counter and clamp cannot serve
    if (ACCESS_LEN_MAX < ACCESS_MIN || ACCESS_LEN_MAX > ACCESS_MAX)
    begin
        $error("ACCESS_LEN_MAX out of range");
    end
    // The phase counter must hold the largest clamped length
    if (ACCESS_LEN_MAX >= (1 << PHASE_W))
    begin
        $error("ACCESS_LEN_MAX too wide for the phase counter");
    end
    // The synchroniser slices its stages for exactly two flops
    if (SYNC_DEPTH != 2)
    begin
        $error("SYNC_DEPTH must be two");
    end

    ready_sync_if rs();

    ready_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ready_pin(ready_pin),
        .sync(rs.src)
    );

    cycle_state_t state;
    cycle_state_t next_state;
    logic [PHASE_W-1:0] count;
    logic [PHASE_W-1:0] next_count;
    logic [PHASE_W-1:0] phase_len;
    logic strobe_n;
    logic next_strobe_n;
    logic is_read;
    logic next_is_read;
    logic use_ready;
    logic next_use_ready;
    logic end_pulse;
    logic next_end_pulse;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic ready_level;
    logic ready_seen;

    // Clamp the programmed length into the served range
    always_comb
    begin
        if (access_phase < PHASE_W'(ACCESS_MIN))
            phase_len = PHASE_W'(ACCESS_MIN);
        else if (access_phase > PHASE_W'(ACCESS_LEN_MAX))
            phase_len = PHASE_W'(ACCESS_LEN_MAX);
        else
            phase_len = access_phase;
    end

    // Async mode costs one waitstate but puts no timing demand on the pin
    // Polarity applied after synchronisation
    always_comb
    begin
        ready_level = ready_async ? rs.ready_synced : rs.ready_direct;
        ready_seen = ready_level == ready_active_high;
    end

    // Cycle sequencing: phase counter and the settings taken at start
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_is_read = is_read;
        next_use_ready = use_ready;
        case (state)
            ST_IDLE:
            begin
                // A start while busy never reaches here, so it is dropped
                if (cycle_start)
                begin
                    next_state = ST_ACCESS;
                    next_count = phase_len;
                    next_is_read = cycle_is_read;
                    next_use_ready = ready_enable;
                end
            end
            ST_ACCESS:
            begin
                // Mandatory waits run out before READY counts
                if (count > PHASE_W'(1))
                    next_count = count - PHASE_W'(1);
                else if (use_ready)
                    next_state = ST_READY_WAIT;
                else
                    next_state = ST_DONE;
            end
            ST_READY_WAIT:
            begin
                // Stays here one waitstate per inactive sample
                if (ready_seen)
                    next_state = ST_DONE;
                else
                    next_state = ST_READY_WAIT;
            end
            ST_DONE:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Direction and READY enable are held from the start, so a change mid-cycle cannot
    // split a cycle between READY and fixed length; polarity and async mode are not held
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            count <= PHASE_RESET;
            is_read <= 1'b0;
            use_ready <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            is_read <= next_is_read;
            use_ready <= next_use_ready;
        end
    end

    // Command strobe and end pulse both change on the edge leaving DONE
    always_comb
    begin
        next_strobe_n = strobe_n;
        next_end_pulse = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (cycle_start)
                    next_strobe_n = 1'b0;
            end
            ST_ACCESS, ST_READY_WAIT:
            begin
                next_strobe_n = 1'b0;
            end
            ST_DONE:
            begin
                next_strobe_n = 1'b1;
                next_end_pulse = 1'b1;
            end
            default:
            begin
                // A stray state must never leave the strobe low
                next_strobe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_n <= 1'b1;
            end_pulse <= 1'b0;
        end
        else
        begin
            strobe_n <= next_strobe_n;
            end_pulse <= next_end_pulse;
        end
    end

    // Read data latch on the edge that raises the strobe
    // Writes leave the last read value standing
    always_comb
    begin
        next_rdata = rdata;
        if (state == ST_DONE && is_read)
            next_rdata = data_in;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= DATA_RESET;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // The bus reference clock is the system clock itself
    assign reference_clock_output = clk_sys;
    assign cmd_strobe_n = strobe_n;
    assign in_ready_wait = state == ST_READY_WAIT;
    assign cycle_end = end_pulse;
    assign read_data = rdata;
    assign busy = state != ST_IDLE;
endmodule

// ---- tb/ready_chk_sva.sv ----
// Port assertions for the READY wait control
`timescale 1ns/1ns
module ready_chk
    import ready_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic ready_pin, // READY
    input wire logic ready_active_high, // polarity
    input wire logic ready_async, // mode
    input wire logic cycle_start, // start
    input wire logic cmd_strobe_n, // strobe
    input wire logic in_ready_wait, // wait
    input wire logic cycle_end, // end
    input wire logic [ready_pkg::DATA_W-1:0] read_data, // data
    input wire logic busy // busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic act = ready_pin == ready_active_high;
    chk_start_taken: assert property (cycle_start && !busy |=> !cmd_strobe_n && busy)
        else $error("start not taken");
    chk_access_first: assert property ($fell(cmd_strobe_n) |-> !in_ready_wait && !cycle_end ##1 !cycle_end)
        else $error("access phase cut");
    chk_wait_again: assert property (in_ready_wait && !(ready_async ? $past(act, 3) : $past(act, 2)) |=> in_ready_wait)
        else $error("wait not held");
    chk_ready_leaves: assert property (in_ready_wait && (ready_async ? $past(act, 3) : $past(act, 2)) |=> !in_ready_wait)
        else $error("ready ignored");
    chk_wait_to_end: assert property ($fell(in_ready_wait) |=> cycle_end)
        else $error("no end after ready");
    chk_end_pulse: assert property (cycle_end |-> cmd_strobe_n && !busy ##1 !cycle_end)
        else $error("bad end pulse");
    chk_strobe_end: assert property ($rose(cmd_strobe_n) |-> cycle_end)
        else $error("strobe rose early");
    chk_data_hold: assert property (!cycle_end |-> $stable(read_data))
        else $error("data moved");
    cover property (in_ready_wait [*3]);
    cover property ($fell(in_ready_wait) && ready_async);
    cover property (cycle_end && !ready_async);
endmodule
bind bus_ready_wait_control ready_chk u_chk (.clk_sys, .rst_n, .ready_pin,
    .ready_active_high, .ready_async, .cycle_start, .cmd_strobe_n,
    .in_ready_wait, .cycle_end, .read_data, .busy);

// ---- tb/ready_responder.sv ----
// External circuit model answering the command strobe with READY
`timescale 1ns/1ns
module ready_responder
(
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic cmd_strobe_n, // strobe
    input wire logic active_high, // polarity
    input wire logic [3:0] delay, // latency
    output logic ready_pin // READY
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic hit;
    // Saturates so a long wait never drops READY early
    assign next_cnt = cmd_strobe_n ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    // Gated by the strobe itself, so READY is gone as soon as the strobe
    // rises and a back-to-back direct-mode cycle never samples it stale
    assign ready_pin = (hit && !cmd_strobe_n) ~^ active_high;
    // Flop driven in step with the clock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 4'h0;
            hit <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            hit <= !cmd_strobe_n && next_cnt >= delay;
        end
    end
endmodule

// ---- tb/tb.sv ----
// Random and corner bus cycles through the READY wait control
`timescale 1ns/1ns
module tb;
    import ready_pkg::*;
    logic clk_sys = 0, rst_n = 0, pol = 1, asy = 0, en = 0, go = 0, rd = 0;
    logic [PHASE_W-1:0] ap = 6'h01;
    logic [DATA_W-1:0] din = 16'h0000, held, rdata;
    logic [3:0] dly = 4'h1;
    logic strb_n, wt, c_end, busy, ready_pin, rclk;
    logic [31:0] s = 32'hf469_5665;
    int bad_count = 0, n_compared = 0, len, n, w, nw;
    always #4 clk_sys = ~clk_sys;
    bus_ready_wait_control #(.ACCESS_LEN_MAX(8)) dut (.clk_sys, .rst_n,
        .reference_clock_output(rclk), .ready_pin, .ready_active_high(pol),
        .ready_async(asy), .ready_enable(en), .access_phase(ap),
        .cycle_start(go), .cycle_is_read(rd), .data_in(din),
        .cmd_strobe_n(strb_n), .in_ready_wait(wt), .cycle_end(c_end),
        .read_data(rdata), .busy);
    ready_responder far (.clk_sys, .rst_n, .cmd_strobe_n(strb_n),
        .active_high(pol), .delay(dly), .ready_pin);
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        bad_count++;
        end_of_test;
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        #1;
        chk("reset", 16'h0008, {12'h000, strb_n, c_end, busy, wt});
        chk("reset data", DATA_RESET, rdata);
        for (int i = 0; i < 40; i++)
        begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            s = s ^ (s << 5);
            @(posedge clk_sys);
            // First two cycles probe both clamp limits of the access count
            ap <= i == 0 ? 6'h00 : (i == 1 ? 6'h0f : {2'h0, s[3:0]});
            {en, asy, pol, rd} <= s[7:4];
            dly <= {1'h0, s[10:8]} + 4'h1;
            din <= s[31:16];
            // Gap lets the synchroniser flush any change of polarity
            repeat (4) @(posedge clk_sys);
            go <= 1;
            @(posedge clk_sys);
            go <= 0;
            held = rdata;
            len = 0;
            nw = 0;
            do
            begin
                @(posedge clk_sys);
                go <= len == 0 && s[11];
                #1;
                if (wt !== 1'b0)
                    nw++;
                len++;
            end while (!c_end && len < 60);
            n = ap < 1 ? 1 : (ap > 8 ? 8 : int'(ap));
            w = !en ? 0 : (dly + 3 + asy > n + 1 ? dly + 3 + asy - n : 1);
            n = en && dly + 3 + asy > n + 1 ? dly + 4 + asy : n + 1 + en;
            chk("length", n[15:0], len[15:0]);
            chk("waitstates", w[15:0], nw[15:0]);
            chk("read data", rd ? din : held, rdata);
            @(posedge clk_sys);
            #1;
            chk("busy", 16'h0000, {15'h0000, busy});
            chk("refclk high", 16'h0001, {15'h0000, rclk});
            @(negedge clk_sys);
            chk("refclk low", 16'h0000, {15'h0000, rclk});
        end
        end_of_test;
    end
endmodule
